// ### rtl/acl_pkg.sv
package acl_pkg;
	// ==========================================
	// register map (word offsets, decoded from address bits 5:2)
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_CFG = 4'h1;
	localparam logic [3:0] OFS_RESULT = 4'h2;
	localparam logic [3:0] OFS_STATUS = 4'h3;
	localparam logic [3:0] OFS_MASK = 4'h4;
	localparam logic [3:0] OFS_PINCTL = 4'h5;
	localparam int ADDR_W = 6;
	// ==========================================
	// control register fields
	localparam int CTRL_CH_LSB = 0;
	localparam int CTRL_CH_W = 5;
	localparam int CTRL_CONT = 5;
	localparam int CTRL_HWTRG = 6;
	localparam int CTRL_IEN = 7;
	localparam int CTRL_START = 8;
	localparam int CTRL_EN = 9;
	// ==========================================
	// config register fields
	localparam int CFG_DIV_LSB = 0;
	localparam int CFG_DIV_W = 2;
	localparam int CFG_ASYNC = 2;
	localparam int CFG_LSMP = 3;
	localparam int CFG_MODE10 = 4;
	localparam int CFG_LPWR = 5;
	// ==========================================
	// status / mask bits
	localparam int ST_DONE = 0;
	localparam int ST_W = 1;
	localparam logic [31:0] BAD_ADDR_DATA = 32'hDEAD_BEEF;
	// ==========================================
	// converter constants
	localparam int NUM_CH = 28;
	localparam int RES_W = 10;
	localparam logic [9:0] FULL10 = 10'h3FF;
	localparam logic [9:0] FULL8 = 10'h0FF;
	localparam logic [9:0] ZERO_CODE = 10'h000;
	// sample phase in half clocks: 3.5 and 23.5 conversion clock cycles
	localparam logic [5:0] SAMP_SHORT_HALF = 6'h07;
	localparam logic [5:0] SAMP_LONG_HALF = 6'h2F;
	localparam int ASYNC_DIV = 4;
	typedef enum logic [1:0] {ACL_IDLE, ACL_SAMPLE, ACL_CONVERT} acl_state_type;
	typedef enum logic [1:0] {PWR_RUN, PWR_LIGHT, PWR_DEEP} acl_pwr_type;
endpackage

// ### rtl/acl_top.sv
// Contract
// - up to 28 analog channels selectable for conversion
// - async conversion clock keeps converting in light stop
// - conversion in progress at light stop entry completes
// - in light stop with the async clock selected, hardware trigger or continuous mode starts conversions
// - each completion sets done flag; enabled interrupt wakes from light stop; only CTRL_IEN wakes, not the mask register
// - converter disables itself on entering either deep stop
// - all registers reset to defaults after deep stop exit
// - config register selects clock source, divider, sample time; low power bit is stored but has no effect
// - 8 or 10 bit, single or continuous, polled or interrupt
// - input at high reference gives full scale code
// - input at low reference gives zero code
// - sampling lasts 3.5 conversion clocks, or 23.5 per long sample
// - pin analog bit disables digital buffer and pullup
// - conversion proceeds even without pin analog bit
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module acl_top (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// avalon-mm slave
	input wire logic [acl_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// system power state and hardware trigger, from pins
	input wire logic light_stop_state,
	input wire logic deep_stop_state,
	input wire logic deepest_stop_state,
	input wire logic hw_trigger,
	// analog front end
	input wire logic [acl_pkg::RES_W-1:0] analog_sample_code,
	input wire logic at_high_ref,
	input wire logic at_low_ref,
	output logic [4:0] analog_channel_select,
	output logic sample_switch,
	output logic [acl_pkg::NUM_CH-1:0] pin_digital_disable,
	// interrupt / wake
	output logic irq,
	output logic wake_req
);
	import acl_pkg::*;

	// ==========================================
	// input synchronisers
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic trg_prev_reg;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			trg_prev_reg <= 1'b0;
		end else begin
			sync1_reg <= {hw_trigger, deepest_stop_state, deep_stop_state, light_stop_state};
			sync2_reg <= sync1_reg;
			trg_prev_reg <= sync2_reg[3];
		end
	end
	logic light_s, deep_s, trg_rise;
	assign light_s = sync2_reg[0];
	assign deep_s = sync2_reg[1] | sync2_reg[2];
	assign trg_rise = sync2_reg[3] & ~trg_prev_reg;

	// ==========================================
	// registers
	logic [9:0] ctrl_reg;
	logic [5:0] converter_config_reg;
	logic [9:0] result_reg;
	logic [ST_W-1:0] status_reg;
	logic [ST_W-1:0] mask_reg;
	logic [NUM_CH-1:0] pinctl_reg;
	logic rd_pend_reg;
	logic [31:0] rdata_reg;
	logic deep_prev_reg;
	logic done_pulse;
	logic start_req;

	logic conversion_done_flag, done_interrupt_enable, long_sample_select, cont_en, conv_en;
	assign conversion_done_flag = status_reg[ST_DONE];
	assign done_interrupt_enable = ctrl_reg[CTRL_IEN];
	assign long_sample_select = converter_config_reg[CFG_LSMP];
	assign cont_en = ctrl_reg[CTRL_CONT];
	assign conv_en = ctrl_reg[CTRL_EN];

	logic wr_hit, rd_hit;
	assign wr_hit = avs_write;
	assign rd_hit = avs_read & ~rd_pend_reg;

	// deep stop wipes all software state; exit finds defaults
	logic wipe;
	assign wipe = deep_s;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= 10'h000;
			converter_config_reg <= 6'h00;
			mask_reg <= 1'b0;
			pinctl_reg <= '0;
		end else if (wipe) begin
			ctrl_reg <= 10'h000;
			converter_config_reg <= 6'h00;
			mask_reg <= 1'b0;
			pinctl_reg <= '0;
		end else begin
			ctrl_reg[CTRL_START] <= 1'b0;
			if (wr_hit && avs_address[5:2] == OFS_CTRL)
				ctrl_reg <= avs_writedata[9:0];
			if (wr_hit && avs_address[5:2] == OFS_CFG)
				converter_config_reg <= avs_writedata[5:0];
			if (wr_hit && avs_address[5:2] == OFS_MASK)
				mask_reg <= avs_writedata[ST_W-1:0];
			if (wr_hit && avs_address[5:2] == OFS_PINCTL)
				pinctl_reg <= avs_writedata[NUM_CH-1:0];
		end
	end

	// analog bit turns off digital buffer and pullup for that pin
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			pin_digital_disable <= '0;
		else
			pin_digital_disable <= pinctl_reg;
	end

	// ==========================================
	// conversion clock enable: bus divider or async source
	logic [3:0] div_cnt_reg;
	logic half_tick;
	logic [3:0] div_lim;
	always_comb begin
		if (converter_config_reg[CFG_ASYNC])
			div_lim = 4'(ASYNC_DIV - 1);
		else
			div_lim = 4'((1 << converter_config_reg[CFG_DIV_LSB+:CFG_DIV_W]) - 1);
	end
	assign half_tick = (div_cnt_reg == div_lim);
	// bus clock gates in light stop unless async clock is in use
	logic clk_alive;
	assign clk_alive = ~light_s | converter_config_reg[CFG_ASYNC];
	// restart the divider on every start so the sample phase spans whole ticks, not a stub
	logic div_restart;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			div_cnt_reg <= 4'h0;
		else if (half_tick || !clk_alive || div_restart)
			div_cnt_reg <= 4'h0;
		else
			div_cnt_reg <= div_cnt_reg + 4'h1;
	end
	logic tick;
	assign tick = half_tick & clk_alive;

	// ==========================================
	// conversion sequencer
	acl_state_type state_reg;
	logic [5:0] cnt_reg;
	logic [3:0] bit_reg;
	logic [9:0] code_reg;
	logic [4:0] chan_reg;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ACL_IDLE;
			cnt_reg <= 6'h00;
			bit_reg <= 4'h0;
			code_reg <= 10'h000;
			chan_reg <= 5'h00;
		end else if (wipe || !conv_en) begin
			state_reg <= ACL_IDLE;
			cnt_reg <= 6'h00;
		end else begin
			case (state_reg)
				ACL_IDLE: begin
					if (start_req) begin
						state_reg <= ACL_SAMPLE;
						// every channel converts regardless of pin bit
						chan_reg <= ctrl_reg[CTRL_CH_LSB+:CTRL_CH_W];
						cnt_reg <= long_sample_select ? SAMP_LONG_HALF : SAMP_SHORT_HALF;
					end
				end
				ACL_SAMPLE: begin
					if (tick) begin
						if (cnt_reg == 6'h01) begin
							state_reg <= ACL_CONVERT;
							bit_reg <= converter_config_reg[CFG_MODE10] ? 4'd10 : 4'd8;
						end
						cnt_reg <= cnt_reg - 6'h01;
					end
				end
				ACL_CONVERT: begin
					// light stop entry does not abort this phase
					if (tick) begin
						bit_reg <= bit_reg - 4'h1;
						if (bit_reg == 4'h1) begin
							if (at_high_ref)
								code_reg <= converter_config_reg[CFG_MODE10] ? FULL10 : FULL8;
							else if (at_low_ref)
								code_reg <= ZERO_CODE;
							else if (converter_config_reg[CFG_MODE10])
								code_reg <= analog_sample_code;
							else
								code_reg <= {2'b00, analog_sample_code[9:2]};
							state_reg <= ACL_IDLE;
						end
					end
				end
				default: state_reg <= ACL_IDLE;
			endcase
		end
	end
	assign done_pulse = (state_reg == ACL_CONVERT) && tick && (bit_reg == 4'h1) && conv_en && !wipe;

	// continuous mode relaunches from idle once the result is in
	logic cont_pend_reg;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			cont_pend_reg <= 1'b0;
		else if (wipe || !cont_en)
			cont_pend_reg <= 1'b0;
		else
			cont_pend_reg <= done_pulse | (cont_pend_reg & state_reg != ACL_IDLE);
	end

	// ==========================================
	// result and done flag (set wins over read clear)
	logic [9:0] result_unused;
	assign result_unused = code_reg;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			result_reg <= 10'h000;
		else if (wipe)
			result_reg <= 10'h000;
		else if (done_pulse)
			result_reg <= at_high_ref ? (converter_config_reg[CFG_MODE10] ? FULL10 : FULL8) :
				at_low_ref ? ZERO_CODE :
				converter_config_reg[CFG_MODE10] ? analog_sample_code :
				{2'b00, analog_sample_code[9:2]};
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			status_reg <= 1'b0;
		else if (wipe)
			status_reg <= 1'b0;
		else if (done_pulse)
			status_reg[ST_DONE] <= 1'b1;
		else if (rd_hit && avs_address[5:2] == OFS_STATUS)
			status_reg <= 1'b0;
	end

	// interrupt: the flag reaches irq through either the mask register or the per-control enable
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
			wake_req <= 1'b0;
		end else begin
			irq <= |(status_reg & mask_reg) | (conversion_done_flag & done_interrupt_enable);
			wake_req <= light_s & conversion_done_flag & done_interrupt_enable;
		end
	end

	// ==========================================
	// analog front end drive
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			analog_channel_select <= 5'h00;
			sample_switch <= 1'b0;
		end else begin
			analog_channel_select <= chan_reg;
			sample_switch <= (state_reg == ACL_SAMPLE);
		end
	end

	// ==========================================
	// bus slave: writes take one edge, reads two (registered data)
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pend_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			rd_pend_reg <= rd_hit;
			if (rd_hit) begin
				case (avs_address[5:2])
					OFS_CTRL: rdata_reg <= {22'h00_0000, ctrl_reg};
					OFS_CFG: rdata_reg <= {26'h000_0000, converter_config_reg};
					OFS_RESULT: rdata_reg <= {22'h00_0000, result_reg};
					OFS_STATUS: rdata_reg <= {31'h0000_0000, status_reg | {ST_W{done_pulse}}};
					OFS_MASK: rdata_reg <= {31'h0000_0000, mask_reg};
					OFS_PINCTL: rdata_reg <= {4'h0, pinctl_reg};
					default: rdata_reg <= BAD_ADDR_DATA;
				endcase
			end
		end
	end
	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = avs_read & ~rd_pend_reg;

	// continuous restart feeds the start path without software
	logic cont_go;
	assign cont_go = cont_pend_reg & (state_reg == ACL_IDLE);
	// light stop: only trigger or continuous restart (software START bit ignored)
	assign start_req = conv_en && clk_alive && (cont_go ||
		(ctrl_reg[CTRL_HWTRG] ? trg_rise : (ctrl_reg[CTRL_START] && !light_s)));
	assign div_restart = (state_reg == ACL_IDLE) && start_req;
	logic unused_ok;
	assign unused_ok = ^result_unused ^ converter_config_reg[CFG_LPWR] ^ deep_prev_reg;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			deep_prev_reg <= 1'b0;
		else
			deep_prev_reg <= deep_s;
	end

	// ==========================================
	// checks
	sequence s_done;
		done_pulse;
	endsequence
	AST_DONE_SETS: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_done |=> conversion_done_flag) else $error("done flag not set");
	AST_DEEP_WIPE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		deep_s |=> ctrl_reg == 10'h000 && converter_config_reg == 6'h00)
		else $error("deep stop left config");
	AST_DEEP_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		deep_s |=> state_reg == ACL_IDLE) else $error("converter active in deep stop");
	AST_SAMPLE_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_reg == ACL_IDLE && start_req && !deep_s && !long_sample_select |=> cnt_reg == 6'h07)
		else $error("short sample length wrong");
	AST_LONG_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_reg == ACL_IDLE && start_req && !deep_s && long_sample_select |=> cnt_reg == 6'h2F)
		else $error("long sample length wrong");
	AST_FULL_SCALE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		done_pulse && at_high_ref && converter_config_reg[CFG_MODE10] |=> result_reg == 10'h3FF)
		else $error("full scale code wrong");
	AST_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
		done_pulse && !at_high_ref && at_low_ref |=> result_reg == 10'h000)
		else $error("zero code wrong");
	AST_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
		conversion_done_flag && done_interrupt_enable |=> irq) else $error("irq missing");
	AST_PIN: assert property (@(posedge ref_clk) disable iff (!rst_n)
		1'b1 |=> pin_digital_disable == $past(pinctl_reg)) else $error("pin control lag");
	AST_KEEP_CONV: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_reg != ACL_IDLE && $rose(light_s) && conv_en && !deep_s && clk_alive
		|=> state_reg != ACL_IDLE || $past(done_pulse)) else $error("conversion aborted");
endmodule // acl_top

// ### dv/acl_top_tb.sv
`timescale 1ns/100ps
module acl_top_tb;
	import acl_pkg::*;
	// ==========================================
	// stimulus and observed signals
	localparam logic [31:0] EN = 32'h0000_0200;
	localparam logic [31:0] START = 32'h0000_0100;
	localparam logic [31:0] IEN = 32'h0000_0080;
	localparam logic [31:0] HWTRG = 32'h0000_0040;
	localparam logic [31:0] CONT = 32'h0000_0020;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic light_stop_state = 1'b0;
	logic deep_stop_state = 1'b0;
	logic deepest_stop_state = 1'b0;
	logic hw_trigger = 1'b0;
	logic [RES_W-1:0] analog_sample_code = 10'h155;
	logic at_high_ref = 1'b0;
	logic at_low_ref = 1'b0;
	logic [4:0] analog_channel_select;
	logic sample_switch;
	logic [NUM_CH-1:0] pin_digital_disable;
	logic irq;
	logic wake_req;
	logic [31:0] rd;
	int miscompares = 0;
	int n_compared = 0;
	int samp_cnt = 0;

	always #2.5 ref_clk = ~ref_clk;
	// counted off the edge so a sample that starts inside a bus task is not missed
	always @(negedge ref_clk) begin
		if (sample_switch === 1'b1) samp_cnt++;
	end

	acl_top acl_top_i (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .light_stop_state, .deep_stop_state,
		.deepest_stop_state, .hw_trigger, .analog_sample_code, .at_high_ref, .at_low_ref,
		.analog_channel_select, .sample_switch, .pin_digital_disable, .irq, .wake_req);

	// ==========================================
	// shared tasks
	task automatic report_and_stop;
		if (miscompares == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// waitrequest is sampled at the rising edge that takes the request; one idle edge follows
	task automatic wr(input logic [3:0] ofs, input logic [31:0] d);
		avs_address <= {ofs, 2'b00};
		avs_writedata <= d;
		avs_write <= 1'b1;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd_reg(input logic [3:0] ofs, output logic [31:0] d);
		avs_address <= {ofs, 2'b00};
		avs_read <= 1'b1;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
		d = avs_readdata;
		avs_read <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wait_out(input bit use_wake, input string msg);
		int k;
		k = 0;
		while (((use_wake ? wake_req : irq) !== 1'b1) && k < 3000) begin
			@(negedge ref_clk);
			k++;
		end
		chk(k < 3000, 32'h1, msg);
		@(posedge ref_clk);
	endtask

	// ==========================================
	// scenarios
	task automatic t_regs_reset;
		logic [3:0] ofs[6] = '{OFS_CTRL, OFS_CFG, OFS_RESULT, OFS_STATUS, OFS_MASK, OFS_PINCTL};
		foreach (ofs[i]) begin
			rd_reg(ofs[i], rd);
			chk(rd, 32'h0, "register not at reset value");
		end
		chk(pin_digital_disable, 32'h0, "pin disables not cleared");
		rd_reg(4'hF, rd);
		chk(rd, BAD_ADDR_DATA, "unmapped read");
	endtask

	task automatic t_convert(input logic [31:0] cfg, input logic hi, input logic lo,
		input logic [31:0] exp, input logic [4:0] ch);
		at_high_ref <= hi;
		at_low_ref <= lo;
		wr(OFS_MASK, 32'h1);
		wr(OFS_CFG, cfg);
		wr(OFS_CTRL, EN | START | 32'(ch));
		wait_out(1'b0, "no irq after conversion");
		chk(analog_channel_select, 32'(ch), "channel select");
		rd_reg(OFS_RESULT, rd);
		chk(rd, exp, "saturated result");
		rd_reg(OFS_STATUS, rd);
		chk(rd, 32'h1, "done flag");
		chk(irq, 32'h0, "irq after status read");
		rd_reg(OFS_STATUS, rd);
		chk(rd, 32'h0, "done flag not cleared by read");
	endtask

	task automatic t_poll;
		int k;
		k = 0;
		rd = '0;
		wr(OFS_MASK, 32'h0);
		wr(OFS_CTRL, EN | START | 32'h5);
		while (rd[ST_DONE] !== 1'b1 && k < 400) begin
			rd_reg(OFS_STATUS, rd);
			chk(irq, 32'h0, "irq while masked");
			k++;
		end
		chk(rd, 32'h1, "polled completion");
	endtask

	task automatic t_sample;
		int len[2];
		for (int s = 0; s < 2; s++) begin
			wr(OFS_MASK, 32'h1);
			wr(OFS_CFG, 32'h1 | 32'(s << CFG_LSMP));
			samp_cnt = 0;
			wr(OFS_CTRL, EN | START);
			wait_out(1'b0, "no irq after sampled conversion");
			len[s] = samp_cnt;
			rd_reg(OFS_STATUS, rd);
		end
		chk(len[0] > 0, 32'h1, "no sample phase seen");
		chk(len[0], 32'(2 * SAMP_SHORT_HALF), "short sample length");
		chk(32'(len[1] * 7), 32'(len[0] * 47), "long/short sample ratio");
	endtask

	task automatic t_light_stop;
		wr(OFS_MASK, 32'h0);
		wr(OFS_CFG, 32'h1 << CFG_ASYNC);
		wr(OFS_CTRL, EN | IEN | START);
		light_stop_state <= 1'b1;
		wait_out(1'b1, "conversion lost in light stop");
		rd_reg(OFS_STATUS, rd);
		chk(wake_req, 32'h0, "wake held after flag read");
		wr(OFS_CTRL, EN | IEN | HWTRG);
		hw_trigger <= 1'b1;
		repeat (3) @(posedge ref_clk);
		hw_trigger <= 1'b0;
		wait_out(1'b1, "trigger ignored in light stop");
		rd_reg(OFS_STATUS, rd);
		light_stop_state <= 1'b0;
		repeat (4) @(posedge ref_clk);
		wr(OFS_CTRL, EN | IEN | CONT | START);
		light_stop_state <= 1'b1;
		wait_out(1'b1, "first continuous result");
		rd_reg(OFS_STATUS, rd);
		wait_out(1'b1, "continuous restart in light stop");
		wr(OFS_CTRL, 32'h0);
		light_stop_state <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic t_deep(input bit deepest);
		wr(OFS_PINCTL, 32'h0A5C_3E91);
		// the pin disables are registered one edge after the write lands
		@(posedge ref_clk);
		chk(pin_digital_disable, 32'h0A5C_3E91, "pin digital disable");
		wr(OFS_CFG, 32'h0000_003F);
		wr(OFS_MASK, 32'h1);
		wr(OFS_CTRL, EN | IEN | CONT | START);
		if (deepest) deepest_stop_state <= 1'b1;
		else deep_stop_state <= 1'b1;
		repeat (200) @(posedge ref_clk);
		chk(irq, 32'h0, "converter ran in deep stop");
		deepest_stop_state <= 1'b0;
		deep_stop_state <= 1'b0;
		repeat (4) @(posedge ref_clk);
		t_regs_reset();
	endtask

	// ==========================================
	// main sequence
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_regs_reset();
		// channel 27 has no pin analog bit set, so conversion must still run
		t_convert(32'h1 << CFG_MODE10, 1'b1, 1'b0, 32'(FULL10), 5'd27);
		t_convert(32'h0, 1'b1, 1'b0, 32'(FULL8), 5'd0);
		t_convert(32'h1 << CFG_MODE10, 1'b0, 1'b1, 32'(ZERO_CODE), 5'd13);
		t_poll();
		t_sample();
		t_light_stop();
		t_deep(1'b0);
		t_deep(1'b1);
		report_and_stop();
	end

	// the sequence needs well under 20000 cycles; this allows a wide margin
	initial begin
		#300000;
		miscompares++;
		report_and_stop();
	end
endmodule // acl_top_tb
